// file: can_node_irq_unit.sv
// Interrupt unit of the CAN node: enables, flags, fault state and pin
module can_node_irq_unit
  import can_irq_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWrData,
  input  wire logic [7:0] regWrMask,
  input  wire logic       regWrEn,
  input  wire logic       regRdEn,
  output logic      [7:0] regRdData,
  input  wire logic [2:0] txEmptyEvt,
  input  wire logic [1:0] rxAcceptEvt,
  input  wire logic       msgErrEvt,
  input  wire logic       busActivity,
  input  wire logic       asleep,
  input  wire logic [8:0] txErrCnt,
  input  wire logic [7:0] rxErrCnt,
  output logic            irqN,
  output logic            wakeReq,
  output logic      [1:0] rxOverrun
);

  // Stored state
  logic [7:0] irqEnable_ff;
  logic [7:0] irqFlag_ff;
  logic [5:0] faultLvl_ff;
  logic [1:0] rxOverrun_ff;
  logic [7:0] regRdData_ff;
  logic       irqN_ff;
  logic       wakeReq_ff;

  // Next values and decoded terms
  logic [7:0] nxt_irqFlag;
  logic [5:0] nxt_faultLvl;
  logic [1:0] nxt_rxOverrun;
  logic [7:0] nxt_regRdData;
  logic [7:0] hwSet;
  logic [7:0] persist;
  logic [7:0] hostSet;
  logic [7:0] hostClr;
  logic [1:0] ovrSet;
  logic       wrEnable;
  logic       wrFlag;
  logic       wrFault;
  logic       faultChange;
  logic       wakeHw;
  logic [8:0] rxErrWide;

  irq_status_if st ();

  irq_prio_encoder u_prio (
    .st (st.encoder)
  );

  assign st.flags   = irqFlag_ff;
  assign st.enables = irqEnable_ff;

  // Register port write decode
  assign wrEnable = regWrEn && (regAddr == IRQ_ENABLE_ADDR);
  assign wrFlag   = regWrEn && (regAddr == IRQ_FLAG_ADDR);
  assign wrFault  = regWrEn && (regAddr == FAULT_STATE_ADDR);

  // Enable register, masked write keeps unmasked bits
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irqEnable_ff <= IRQ_ENABLE_RST;  // see R22
    end else if (wrEnable) begin
      irqEnable_ff <= (irqEnable_ff & ~regWrMask) | (regWrData & regWrMask);  // see R01 see R18
    end
  end

  // Error counter levels
  assign rxErrWide = {1'b0, rxErrCnt};

  always_comb begin
    nxt_faultLvl             = FAULT_LVL_RST;
    nxt_faultLvl[FLT_RXWARN] = rxErrWide >= WARN_LIMIT;     // see R15
    nxt_faultLvl[FLT_TXWARN] = txErrCnt >= WARN_LIMIT;      // see R15
    nxt_faultLvl[FLT_EWARN]  = nxt_faultLvl[FLT_RXWARN] || nxt_faultLvl[FLT_TXWARN];
    nxt_faultLvl[FLT_RXPASS] = rxErrWide > PASSIVE_LIMIT;   // see R16
    nxt_faultLvl[FLT_TXPASS] = txErrCnt > PASSIVE_LIMIT;    // see R16
    nxt_faultLvl[FLT_BUSOFF] = txErrCnt > BUSOFF_LIMIT;     // see R17
  end

  // Fault levels follow the counters
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      faultLvl_ff <= FAULT_LVL_RST;
    end else begin
      faultLvl_ff <= nxt_faultLvl;
    end
  end

  // Any error-state condition change
  assign faultChange = nxt_faultLvl != faultLvl_ff;  // see R13

  // Overrun: accepted message while receive flag still one
  assign ovrSet = rxAcceptEvt & {irqFlag_ff[SRC_RX1], irqFlag_ff[SRC_RX0]};  // see R14 see R20

  // Overrun bits: only host clears, set wins
  always_comb begin
    nxt_rxOverrun = rxOverrun_ff;
    if (wrFault) begin
      nxt_rxOverrun = rxOverrun_ff & ~(regWrMask[7:6] & ~regWrData[7:6]);
    end
    nxt_rxOverrun = nxt_rxOverrun | ovrSet;  // see R21 see R20
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rxOverrun_ff <= RX_OVERRUN_RST;
    end else begin
      rxOverrun_ff <= nxt_rxOverrun;
    end
  end

  // Bus activity while asleep with wake enabled
  assign wakeHw = asleep && busActivity && irqEnable_ff[SRC_WAKE];  // see R12

  // Hardware set events per source
  always_comb begin
    hwSet            = IRQ_FLAG_RST;
    hwSet[SRC_RX0]   = rxAcceptEvt[0];  // see R10
    hwSet[SRC_RX1]   = rxAcceptEvt[1];  // see R10
    hwSet[SRC_TX0]   = txEmptyEvt[0];   // see R09
    hwSet[SRC_TX1]   = txEmptyEvt[1];   // see R09
    hwSet[SRC_TX2]   = txEmptyEvt[2];   // see R09
    hwSet[SRC_STATE] = faultChange || (|ovrSet);  // see R13
    hwSet[SRC_WAKE]  = wakeHw;          // see R12
    hwSet[SRC_MSG]   = msgErrEvt;       // see R11
  end

  // Conditions that still prevail beyond the set event
  always_comb begin
    persist            = hwSet;
    persist[SRC_STATE] = hwSet[SRC_STATE] || (|rxOverrun_ff);
    persist[SRC_WAKE]  = asleep && busActivity;
  end

  // Host write terms from the masked write
  assign hostSet = wrFlag ? (regWrMask & regWrData) : IRQ_FLAG_RST;   // see R05 see R04
  assign hostClr = wrFlag ? (regWrMask & ~regWrData) : IRQ_FLAG_RST;  // see R04

  // Flag next value per bit
  for (genvar i = 0; i < NUM_SRC; i++) begin : g_flag
    always_comb begin
      nxt_irqFlag[i] = irqFlag_ff[i];
      if (hostClr[i] && !persist[i]) begin
        nxt_irqFlag[i] = 1'b0;  // see R03
      end
      if (hostSet[i] || hwSet[i]) begin
        nxt_irqFlag[i] = 1'b1;  // see R21 see R05
      end
    end
  end

  // Flag register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irqFlag_ff <= IRQ_FLAG_RST;  // see R22
    end else begin
      irqFlag_ff <= nxt_irqFlag;   // see R19 see R01
    end
  end

  // Interrupt pin, low while an enabled flag is pending
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irqN_ff <= 1'b1;  // see R22
    end else begin
      irqN_ff <= ~st.pending;  // see R02 see R05
    end
  end

  // Wake request pulse on a newly set, enabled wake flag while asleep
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wakeReq_ff <= 1'b0;
    end else begin
      wakeReq_ff <= asleep && irqEnable_ff[SRC_WAKE] &&
                    nxt_irqFlag[SRC_WAKE] && !irqFlag_ff[SRC_WAKE];  // see R12
    end
  end

  // Read data select, unmapped reads zero
  always_comb begin
    nxt_regRdData = READ_ZERO;
    case (regAddr)
      IRQ_ENABLE_ADDR: begin
        nxt_regRdData = irqEnable_ff;
      end
      IRQ_FLAG_ADDR: begin
        nxt_regRdData = irqFlag_ff;  // see R19
      end
      FAULT_STATE_ADDR: begin
        nxt_regRdData = {rxOverrun_ff, faultLvl_ff};
      end
      NODE_STATE_ADDR: begin
        nxt_regRdData[CODE_LSB +: 3] = st.code;  // see R06 see R08
      end
      default: begin
        nxt_regRdData = READ_ZERO;
      end
    endcase
  end

  // Read data held until the next read
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      regRdData_ff <= READ_ZERO;  // see R22
    end else if (regRdEn) begin
      regRdData_ff <= nxt_regRdData;
    end
  end

  // Outputs straight from flip-flops
  assign regRdData = regRdData_ff;
  assign irqN      = irqN_ff;
  assign wakeReq   = wakeReq_ff;
  assign rxOverrun = rxOverrun_ff;

endmodule

// file: can_irq_pkg.sv
// Constants shared by the CAN node interrupt unit and its helpers
//
// Contract
// R01: Eight sources, each enable and flag bit
// R02: Interrupt pin low while enabled flag set
// R03: Host clear refused while condition persists
// R04: Host should clear flags with masked write
// R05: Host setting enabled flag raises interrupt
// R06: Three-bit code, lower value higher priority
// R07: Code moves to next pending source
// R08: Disabled flags never appear in code
// R09: Transmit buffer empty sets its flag
// R10: Accepted received message sets receive flag
// R11: Any message error sets message-fault flag
// R12: Bus activity asleep sets wake flag, exits; code sets it only with wake enabled
// R13: Overflow or error-state change sets state-fault
// R14: Accepted message into occupied buffer sets overrun
// R15: Warning when error counter reaches 96
// R16: Error-passive when error counter exceeds 127
// R17: Bus-off when transmit counter exceeds 255
// R18: Enable bit order fault, wake, state, tx, rx
// R19: Flag register uses same bit order
// R20: Overrun set while receive flag one, host clears
// R21: Hardware set beats same-cycle host clear
// R22: Reset clears bits, releases pin, code none
package can_irq_pkg;

  // Register port addresses
  localparam logic [7:0] IRQ_ENABLE_ADDR  = 8'h2b;
  localparam logic [7:0] IRQ_FLAG_ADDR    = 8'h2c;
  localparam logic [7:0] FAULT_STATE_ADDR = 8'h2d;
  localparam logic [7:0] NODE_STATE_ADDR  = 8'h2f;

  // Reset values
  localparam logic [7:0] IRQ_ENABLE_RST  = 8'h00;
  localparam logic [7:0] IRQ_FLAG_RST    = 8'h00;
  localparam logic [5:0] FAULT_LVL_RST   = 6'h00;
  localparam logic [1:0] RX_OVERRUN_RST  = 2'h0;
  localparam logic [7:0] READ_ZERO       = 8'h00;

  // Source bit positions in enable and flag registers
  localparam int SRC_RX0   = 0;
  localparam int SRC_RX1   = 1;
  localparam int SRC_TX0   = 2;
  localparam int SRC_TX1   = 3;
  localparam int SRC_TX2   = 4;
  localparam int SRC_STATE = 5;
  localparam int SRC_WAKE  = 6;
  localparam int SRC_MSG   = 7;
  localparam int NUM_SRC   = 8;

  // Fault state register fields
  localparam int FLT_EWARN  = 0;
  localparam int FLT_RXWARN = 1;
  localparam int FLT_TXWARN = 2;
  localparam int FLT_RXPASS = 3;
  localparam int FLT_TXPASS = 4;
  localparam int FLT_BUSOFF = 5;

  // Source code field position in node state register
  localparam int CODE_LSB = 1;

  // Error counter limits
  localparam logic [8:0] WARN_LIMIT    = 9'h060;
  localparam logic [8:0] PASSIVE_LIMIT = 9'h07f;
  localparam logic [8:0] BUSOFF_LIMIT  = 9'h0ff;

  // Source codes, lower value wins
  localparam logic [2:0] CODE_NONE  = 3'h0;
  localparam logic [2:0] CODE_ERROR = 3'h1;
  localparam logic [2:0] CODE_WAKE  = 3'h2;
  localparam logic [2:0] CODE_TX0   = 3'h3;
  localparam logic [2:0] CODE_TX1   = 3'h4;
  localparam logic [2:0] CODE_TX2   = 3'h5;
  localparam logic [2:0] CODE_RX0   = 3'h6;
  localparam logic [2:0] CODE_RX1   = 3'h7;

endpackage

// file: irq_status_if.sv
// Interface carrying flags, enables and the prioritised code
interface irq_status_if;
  logic [7:0] flags;
  logic [7:0] enables;
  logic [2:0] code;
  logic       pending;

  modport producer (output flags, output enables, input code, input pending);
  modport encoder  (input flags, input enables, output code, output pending);
endinterface

// file: irq_prio_encoder.sv
// Priority encoder producing the interrupt source code
module irq_prio_encoder
  import can_irq_pkg::*;
(
  irq_status_if.encoder st
);

  logic [7:0] active;
  logic [2:0] codeOf [NUM_SRC];

  // Code per source bit; message fault carries no code
  always_comb begin
    codeOf[SRC_RX0]   = CODE_RX0;
    codeOf[SRC_RX1]   = CODE_RX1;
    codeOf[SRC_TX0]   = CODE_TX0;
    codeOf[SRC_TX1]   = CODE_TX1;
    codeOf[SRC_TX2]   = CODE_TX2;
    codeOf[SRC_STATE] = CODE_ERROR;
    codeOf[SRC_WAKE]  = CODE_WAKE;
    codeOf[SRC_MSG]   = CODE_NONE;
  end

  // Only enabled flags count
  assign active     = st.flags & st.enables;  // see R08
  assign st.pending = |active;                // see R02

  // Smallest code among active sources wins
  always_comb begin
    st.code = CODE_NONE;
    for (int i = 0; i < NUM_SRC; i++) begin
      if (active[i] && codeOf[i] != CODE_NONE &&
          (st.code == CODE_NONE || codeOf[i] < st.code)) begin
        st.code = codeOf[i];  // see R06 see R07
      end
    end
  end

endmodule

// file: can_irq_properties.sv
// Port-level assertions for the interrupt unit
module can_irq_properties
  import can_irq_pkg::*;
(
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic [7:0] regAddr,
  input wire logic       regRdEn,
  input wire logic       regWrEn,
  input wire logic [7:0] regRdData,
  input wire logic [1:0] rxAcceptEvt,
  input wire logic       asleep,
  input wire logic       irqN,
  input wire logic       wakeReq,
  input wire logic [1:0] rxOverrun
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Read strobe at one address, and the one-cycle wake pulse
  sequence s_rd(a);
    regRdEn && regAddr == a;
  endsequence
  sequence s_pulse;
    wakeReq ##1 !wakeReq;
  endsequence
  property p_reset;
    disable iff (1'b0) sys_rst |=> irqN && !wakeReq && rxOverrun == 2'h0 && regRdData == 8'h00;
  endproperty
  property p_irq_hold;
    !irqN && !regWrEn && !$past(regWrEn) |=> !irqN;
  endproperty
  property p_code;
    s_rd(NODE_STATE_ADDR) |=> regRdData[3:1] == CODE_NONE || !irqN;
  endproperty
  property p_node;
    s_rd(NODE_STATE_ADDR) |=> regRdData[7:4] == 4'h0 && !regRdData[0];
  endproperty
  property p_ovr_rd;
    s_rd(FAULT_STATE_ADDR) |=> regRdData[7:6] == $past(rxOverrun);
  endproperty
  property p_ovr_set;
    $rose(rxOverrun[0]) |-> $past(rxAcceptEvt[0]);
  endproperty
  property p_ovr_hold;
    rxOverrun[1] && !regWrEn |=> rxOverrun[1];
  endproperty
  property p_wake;
    wakeReq |-> $past(asleep) ##0 s_pulse;
  endproperty
  a_reset: assert property (p_reset) else $error("reset state wrong");
  a_irq_hold: assert property (p_irq_hold) else $error("pin released early");
  a_code: assert property (p_code) else $error("code without pin");
  a_node: assert property (p_node) else $error("node state spare bits");
  a_ovr_rd: assert property (p_ovr_rd) else $error("overrun read wrong");
  a_ovr_set: assert property (p_ovr_set) else $error("overrun without cause");
  a_ovr_hold: assert property (p_ovr_hold) else $error("overrun lost");
  a_wake: assert property (p_wake) else $error("wake pulse wrong");
endmodule
bind can_node_irq_unit can_irq_properties chk (.clk, .sys_rst, .regAddr, .regRdEn, .regWrEn,
  .regRdData, .rxAcceptEvt, .asleep, .irqN, .wakeReq, .rxOverrun);

// file: can_host_model.sv
// Host model driving the register port
module can_host_model (
  input  wire logic       clk,
  input  wire logic [7:0] regRdData,
  output logic      [7:0] regAddr,
  output logic      [7:0] regWrData,
  output logic      [7:0] regWrMask,
  output logic            regWrEn,
  output logic            regRdEn
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {regAddr, regWrData, regWrMask, regWrEn, regRdEn} = '0;
  end
  // Masked write; data scrambled once released
  task automatic wr(input logic [7:0] a, d, m);
    @(negedge clk);
    {regAddr, regWrData, regWrMask, regWrEn} = {a, d, m, 1'b1};
    @(negedge clk);
    {regWrEn, regWrData} = {1'b0, ~d};
  endtask
  // Clear flags under mask only
  task automatic clr(input logic [7:0] a, m);
    wr(a, 8'h00, m);
  endtask
  // Read, data taken one cycle on
  task automatic rd(input logic [7:0] a, output logic [7:0] x);
    @(negedge clk);
    {regAddr, regRdEn} = {a, 1'b1};
    @(negedge clk);
    regRdEn = 1'b0;
    x = regRdData;
  endtask
endmodule

// file: tb.sv
// Self-checking bench for the interrupt unit
module tb;
  import can_irq_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [2:0] t; logic [1:0] r; logic m; logic [7:0] f; logic [2:0] c;} row_t;
  typedef struct {logic [8:0] t; logic [7:0] r, f;} cnt_t;
  logic       clk, sys_rst, regWrEn, regRdEn, msgErrEvt, busActivity, asleep, irqN, wakeReq;
  logic [7:0] regAddr, regWrData, regWrMask, regRdData, rxErrCnt, v;
  logic [2:0] txEmptyEvt;
  logic [1:0] rxAcceptEvt, rxOverrun;
  logic [8:0] txErrCnt;
  int         mismatches, comparisons;
  row_t rows [6] = '{'{3'h1, 2'h0, 1'b0, 8'h04, CODE_TX0}, '{3'h2, 2'h0, 1'b0, 8'h08, CODE_TX1},
    '{3'h4, 2'h0, 1'b0, 8'h10, CODE_TX2}, '{3'h0, 2'h1, 1'b0, 8'h01, CODE_RX0},
    '{3'h0, 2'h2, 1'b0, 8'h02, CODE_RX1}, '{3'h0, 2'h0, 1'b1, 8'h80, CODE_NONE}};
  cnt_t cnts [7] = '{'{9'h05f, 8'h00, 8'h00}, '{9'h060, 8'h00, 8'h05}, '{9'h07f, 8'h00, 8'h05},
    '{9'h080, 8'h00, 8'h15}, '{9'h100, 8'h00, 8'h35}, '{9'h000, 8'h60, 8'h03},
    '{9'h000, 8'h80, 8'h0b}};
  logic [2:0] pc [5] = '{CODE_ERROR, CODE_TX0, CODE_TX1, CODE_TX2, CODE_NONE};
  logic [7:0] pm [4] = '{8'h20, 8'h04, 8'h08, 8'h10};
  can_host_model host (.clk, .regRdData, .regAddr, .regWrData, .regWrMask, .regWrEn, .regRdEn);
  can_node_irq_unit dut (.clk, .sys_rst, .regAddr, .regWrData, .regWrMask, .regWrEn, .regRdEn,
    .regRdData, .txEmptyEvt, .rxAcceptEvt, .msgErrEvt, .busActivity, .asleep, .txErrCnt,
    .rxErrCnt, .irqN, .wakeReq, .rxOverrun);
  // Clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Compare and count
  task automatic chk(input string n, input logic [7:0] s, e);
    comparisons++;
    if (s !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic rc(input logic [7:0] a, e, input string n);
    host.rd(a, v);
    chk(n, v, e);
  endtask
  // One-cycle event pulse
  task automatic ev(input logic [2:0] t, input logic [1:0] r, input logic m);
    @(negedge clk);
    {txEmptyEvt, rxAcceptEvt, msgErrEvt} = {t, r, m};
    @(negedge clk);
    {txEmptyEvt, rxAcceptEvt, msgErrEvt} = '0;
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Watchdog
  initial begin
    #40000;
    mismatches++;
    wrap_up();
  end
  // Main sequence
  initial begin
    {sys_rst, txEmptyEvt, rxAcceptEvt, msgErrEvt, busActivity, asleep} = 9'h100;
    {txErrCnt, rxErrCnt} = '0;
    repeat (16) @(negedge clk);
    sys_rst = 1'b0;
    rc(IRQ_ENABLE_ADDR, 8'h00, "enable");
    rc(IRQ_FLAG_ADDR, 8'h00, "flags");
    chk("pin", {7'h0, irqN}, 8'h01);
    rc(8'h2e, 8'h00, "unmapped");
    $display("test reset done");
    host.wr(IRQ_ENABLE_ADDR, 8'hff, 8'hff);
    foreach (rows[i]) begin
      ev(rows[i].t, rows[i].r, rows[i].m);
      rc(IRQ_FLAG_ADDR, rows[i].f, "flags");
      rc(NODE_STATE_ADDR, {4'h0, rows[i].c, 1'b0}, "code");
      chk("pin", {7'h0, irqN}, 8'h00);
      host.clr(IRQ_FLAG_ADDR, 8'hff);
      @(negedge clk);
      chk("pin off", {7'h0, irqN}, 8'h01);
    end
    $display("test table done");
    host.wr(IRQ_FLAG_ADDR, 8'h3c, 8'hff);
    @(negedge clk);
    chk("host set", {7'h0, irqN}, 8'h00);
    for (int k = 0; k < 5; k++) begin
      rc(NODE_STATE_ADDR, {4'h0, pc[k], 1'b0}, "next code");
      if (k < 4) host.clr(IRQ_FLAG_ADDR, pm[k]);
    end
    host.wr(IRQ_ENABLE_ADDR, 8'h00, 8'hff);
    host.wr(IRQ_FLAG_ADDR, 8'h04, 8'h04);
    rc(NODE_STATE_ADDR, 8'h00, "masked");
    chk("masked pin", {7'h0, irqN}, 8'h01);
    host.wr(IRQ_ENABLE_ADDR, 8'hff, 8'hff);
    rc(NODE_STATE_ADDR, {4'h0, CODE_TX0, 1'b0}, "unmasked");
    $display("test priority done");
    fork
      host.clr(IRQ_FLAG_ADDR, 8'h84);
      ev(3'h1, 2'h0, 1'b1);
    join
    rc(IRQ_FLAG_ADDR, 8'h84, "clear refused");
    host.clr(IRQ_FLAG_ADDR, 8'hff);
    repeat (2) ev(3'h0, 2'h3, 1'b0);
    rc(FAULT_STATE_ADDR, 8'hc0, "overrun");
    host.clr(IRQ_FLAG_ADDR, 8'h20);
    rc(IRQ_FLAG_ADDR, 8'h23, "overrun flags");
    host.wr(FAULT_STATE_ADDR, 8'hff, 8'hc0);
    chk("overrun kept", {6'h0, rxOverrun}, 8'h03);
    host.clr(FAULT_STATE_ADDR, 8'hc0);
    chk("overrun off", {6'h0, rxOverrun}, 8'h00);
    host.clr(IRQ_FLAG_ADDR, 8'hff);
    $display("test clear done");
    {asleep, busActivity} = 2'h3;
    @(negedge clk);
    chk("wake", {7'h0, wakeReq}, 8'h01);
    {asleep, busActivity} = 2'h0;
    rc(NODE_STATE_ADDR, {4'h0, CODE_WAKE, 1'b0}, "wake code");
    host.clr(IRQ_FLAG_ADDR, 8'hff);
    foreach (cnts[i]) begin
      {txErrCnt, rxErrCnt} = {cnts[i].t, cnts[i].r};
      rc(FAULT_STATE_ADDR, cnts[i].f, "fault levels");
    end
    rc(IRQ_FLAG_ADDR, 8'h20, "state fault");
    $display("test wake and levels done");
    {txErrCnt, rxErrCnt} = '0;
    host.wr(IRQ_FLAG_ADDR, 8'h04, 8'h04);
    sys_rst = 1'b1;
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    chk("reset pin", {7'h0, irqN}, 8'h01);
    chk("reset overrun", {6'h0, rxOverrun}, 8'h00);
    rc(IRQ_ENABLE_ADDR, 8'h00, "reset enable");
    rc(IRQ_FLAG_ADDR, 8'h00, "reset flags");
    rc(NODE_STATE_ADDR, 8'h00, "reset code");
    $display("test mid-run reset done");
    wrap_up();
  end
endmodule
